// file: src/pasid_entry_pkg.sv
// constants, field layouts and register map of the pasid entry state handler
package pasid_entry_pkg;
  // ----------------------------------------------------------------------
  // extended context entry fields
  // ----------------------------------------------------------------------
  localparam int CTX_PRESENT_BIT = 0;
  localparam int CTX_FAULT_SUPPRESS_BIT = 1;
  // ----------------------------------------------------------------------
  // pasid table entry fields
  // ----------------------------------------------------------------------
  localparam int PTE_VALID_BIT = 0;
  localparam int PTE_WRITE_THROUGH_BIT = 3;
  localparam int PTE_CACHE_DISABLE_BIT = 4;
  localparam int PTE_SUPERVISOR_BIT = 11;
  localparam int PTE_ROOT_LSB = 12;
  localparam int PTE_ROOT_MSB = 63;
  localparam logic [63:0] PTE_RSVD_MASK = 64'h0000_0000_0000_07E6;
  // ----------------------------------------------------------------------
  // pasid state entry fields
  // ----------------------------------------------------------------------
  localparam int PSE_DEFER_BIT = 63;
  localparam int PSE_COUNT_LSB = 32;
  localparam int PSE_COUNT_MSB = 47;
  localparam logic [63:0] PSE_RSVD_MASK = 64'h7FFF_0000_FFFF_FFFF;
  // ----------------------------------------------------------------------
  // memory types used for top-level table fetches
  // ----------------------------------------------------------------------
  localparam logic [1:0] MT_WRITE_BACK = 2'h0;
  localparam logic [1:0] MT_WRITE_THROUGH = 2'h1;
  localparam logic [1:0] MT_UNCACHED_MINUS = 2'h2;
  localparam logic [1:0] MT_UNCACHED = 2'h3;
  // ----------------------------------------------------------------------
  // apb register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_LAST_COUNT = 8'h0C;
  localparam logic [7:0] REG_FAULT_COUNT = 8'h10;
  // control bits
  localparam int CTRL_SUPERVISOR_CAP = 0;
  localparam int CTRL_MEMTYPE_CAP = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  // status event bits
  localparam int EV_FAULT = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_COUNT_ZERO = 2;
  localparam int EV_WIDTH = 3;
  // fault reasons
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_CTX_ABSENT = 3'h1;
  localparam logic [2:0] FLT_PASID_INVALID = 3'h2;
  localparam logic [2:0] FLT_RESERVED = 3'h3;
  localparam logic [2:0] FLT_SUPERVISOR = 3'h4;
  // update operations
  localparam logic UPD_ACTIVATE = 1'b1;
  localparam logic UPD_DEACTIVATE = 1'b0;
endpackage

// file: src/pasid_entry_state_handler.sv
// pasid entry decode and pasid state update engine with apb registers
`timescale 1ns/10ps
module pasid_entry_state_handler #(
  parameter int HOST_ADDR_WIDTH = 48,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // translation lookup request
  input wire logic i_lookup_valid,
  input wire logic [63:0] i_ctx_entry,
  input wire logic i_nested_translation_enable,
  input wire logic [63:0] i_pasid_entry,
  input wire logic i_supervisor_req,
  input wire logic i_coherent_domain,
  output logic o_lookup_done,
  output logic o_lookup_ok,
  output logic [63:0] o_first_level_root_pointer,
  output logic o_root_is_guest_physical,
  output logic [1:0] o_table_memory_type,
  output logic o_fault_report,
  output logic [2:0] o_fault_reason,
  // pasid state update request
  input wire logic i_update_valid,
  input wire logic i_update_activate,
  input wire logic [63:0] i_update_addr,
  output logic o_update_ready,
  output logic o_update_done,
  output logic o_sync_flag,
  output logic o_pasid_in_use,
  // memory port for the locked read-modify-write
  output logic o_mem_req,
  output logic o_mem_write,
  output logic o_mem_lock,
  output logic [63:0] o_mem_addr,
  output logic [63:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [63:0] i_mem_rdata,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // mask of root pointer bits from 63 down to the host address width
  function automatic logic [63:0] above_host_width_mask();
    logic [63:0] m;
    m = '1;
    m = m << HOST_ADDR_WIDTH;
    return m;
  endfunction
  // memory type from cache disable and write through
  function automatic logic [1:0] pick_type(input logic cd, input logic wt);
    logic [1:0] t;
    t = pasid_entry_pkg::MT_WRITE_BACK;
    case ({cd, wt})
      2'h1: t = pasid_entry_pkg::MT_WRITE_THROUGH;
      2'h2: t = pasid_entry_pkg::MT_UNCACHED_MINUS;
      2'h3: t = pasid_entry_pkg::MT_UNCACHED;
      default: t = pasid_entry_pkg::MT_WRITE_BACK;
    endcase
    return t;
  endfunction
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next; // capability controls
  logic [2:0] status_reg, status_next; // sticky events
  logic [2:0] mask_reg, mask_next; // interrupt enables
  logic [31:0] fault_cnt_reg, fault_cnt_next; // reported faults
  logic [31:0] last_cnt_reg, last_cnt_next; // last written count
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  // lookup outputs
  logic look_done_reg, look_done_next;
  logic look_ok_reg, look_ok_next;
  logic [63:0] root_reg, root_next;
  logic guest_reg, guest_next;
  logic [1:0] mtype_reg, mtype_next;
  logic frep_reg, frep_next;
  logic [2:0] freason_reg, freason_next;
  // update engine
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_DONE = 4'h8
  } upd_state_t;
  upd_state_t state_reg, state_next;
  logic act_reg, act_next; // latched operation
  logic [63:0] addr_reg, addr_next;
  logic [63:0] wdata_reg, wdata_next;
  logic sync_reg, sync_next;
  logic inuse_reg, inuse_next;
  logic udone_reg, udone_next;
  logic idle_reg, idle_next, busy_reg, busy_next, wr_reg, wr_next; // handshake outputs
  // ----------------------------------------------------------------------
  // lookup decode
  // ----------------------------------------------------------------------
  logic ctx_present;
  logic suppress;
  logic pasid_valid;
  logic rsvd_fault;
  logic sup_fault;
  logic [63:0] rsvd_mask;
  logic [2:0] reason;
  logic fault_event;
  // decode the two entries and pick the first fault
  always_comb begin
    ctx_present = i_ctx_entry[pasid_entry_pkg::CTX_PRESENT_BIT];
    // fault suppress read regardless of present
    suppress = i_ctx_entry[pasid_entry_pkg::CTX_FAULT_SUPPRESS_BIT];
    pasid_valid = i_pasid_entry[pasid_entry_pkg::PTE_VALID_BIT];
    rsvd_mask = pasid_entry_pkg::PTE_RSVD_MASK | above_host_width_mask();
    if (!ctrl_reg[pasid_entry_pkg::CTRL_SUPERVISOR_CAP]) begin
      rsvd_mask[pasid_entry_pkg::PTE_SUPERVISOR_BIT] = 1'b1;
    end
    if (!ctrl_reg[pasid_entry_pkg::CTRL_MEMTYPE_CAP]) begin
      rsvd_mask[pasid_entry_pkg::PTE_CACHE_DISABLE_BIT] = 1'b1;
      rsvd_mask[pasid_entry_pkg::PTE_WRITE_THROUGH_BIT] = 1'b1;
    end
    rsvd_fault = |(i_pasid_entry & rsvd_mask);
    sup_fault = i_supervisor_req && !i_pasid_entry[pasid_entry_pkg::PTE_SUPERVISOR_BIT];
    if (!ctx_present) begin
      reason = pasid_entry_pkg::FLT_CTX_ABSENT;
    end else if (!pasid_valid) begin
      reason = pasid_entry_pkg::FLT_PASID_INVALID;
    end else if (rsvd_fault) begin
      reason = pasid_entry_pkg::FLT_RESERVED;
    end else if (sup_fault) begin
      reason = pasid_entry_pkg::FLT_SUPERVISOR;
    end else begin
      reason = pasid_entry_pkg::FLT_NONE;
    end
    // suppressed faults are neither recorded nor reported
    fault_event = i_lookup_valid && (reason != pasid_entry_pkg::FLT_NONE) && !suppress;
  end

  // next values of the lookup outputs
  always_comb begin
    look_done_next = i_lookup_valid;
    look_ok_next = i_lookup_valid && (reason == pasid_entry_pkg::FLT_NONE);
    root_next = root_reg;
    guest_next = guest_reg;
    mtype_next = mtype_reg;
    frep_next = fault_event;
    freason_next = i_lookup_valid ? reason : freason_reg;
    if (i_lookup_valid && reason == pasid_entry_pkg::FLT_NONE) begin
      root_next = {i_pasid_entry[pasid_entry_pkg::PTE_ROOT_MSB:pasid_entry_pkg::PTE_ROOT_LSB],
                   12'h000};
      guest_next = i_nested_translation_enable;
      if (i_coherent_domain && ctrl_reg[pasid_entry_pkg::CTRL_MEMTYPE_CAP]) begin
        mtype_next = pick_type(i_pasid_entry[pasid_entry_pkg::PTE_CACHE_DISABLE_BIT],
                               i_pasid_entry[pasid_entry_pkg::PTE_WRITE_THROUGH_BIT]);
      end else begin
        mtype_next = pasid_entry_pkg::MT_WRITE_BACK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pasid state update engine
  // ----------------------------------------------------------------------
  logic [COUNT_WIDTH-1:0] cur_cnt;
  logic [COUNT_WIDTH-1:0] new_cnt;
  logic sync_event;
  logic zero_event;
  // locked read then write of the state entry
  always_comb begin
    state_next = state_reg;
    act_next = act_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    sync_next = sync_reg;
    inuse_next = inuse_reg;
    udone_next = 1'b0;
    sync_event = 1'b0;
    zero_event = 1'b0;
    cur_cnt = i_mem_rdata[pasid_entry_pkg::PSE_COUNT_MSB:pasid_entry_pkg::PSE_COUNT_LSB];
    new_cnt = cur_cnt;
    case (state_reg)
      // accept a new update
      ST_IDLE: begin
        if (i_update_valid) begin
          act_next = i_update_activate;
          addr_next = i_update_addr;
          state_next = ST_READ;
        end
      end
      // locked read, compute new entry
      ST_READ: begin
        if (i_mem_ack) begin
          wdata_next = i_mem_rdata & ~pasid_entry_pkg::PSE_RSVD_MASK;
          if (act_reg == pasid_entry_pkg::UPD_ACTIVATE) begin
            new_cnt = cur_cnt + 1'b1;
            sync_next = i_mem_rdata[pasid_entry_pkg::PSE_DEFER_BIT];
            sync_event = i_mem_rdata[pasid_entry_pkg::PSE_DEFER_BIT];
            wdata_next[pasid_entry_pkg::PSE_DEFER_BIT] = 1'b0;
          end else begin
            new_cnt = cur_cnt - 1'b1;
            sync_next = 1'b0;
          end
          wdata_next[pasid_entry_pkg::PSE_COUNT_MSB:pasid_entry_pkg::PSE_COUNT_LSB] = new_cnt;
          inuse_next = (new_cnt != '0);
          zero_event = (new_cnt == '0);
          state_next = ST_WRITE;
        end
      end
      // locked write back
      ST_WRITE: begin
        if (i_mem_ack) begin
          state_next = ST_DONE;
        end
      end
      // pulse the response
      ST_DONE: begin
        udone_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    idle_next = (state_next == ST_IDLE);
    busy_next = (state_next == ST_READ) || (state_next == ST_WRITE);
    wr_next = (state_next == ST_WRITE);
  end

  // ----------------------------------------------------------------------
  // apb slave and interrupt
  // ----------------------------------------------------------------------
  logic apb_access;
  logic [2:0] events;
  logic hit;

  // register decode, status read clears, events win over the clear
  always_comb begin
    apb_access = i_psel && i_penable && !pready_reg;
    events = '0;
    events[pasid_entry_pkg::EV_FAULT] = fault_event;
    events[pasid_entry_pkg::EV_SYNC] = sync_event;
    events[pasid_entry_pkg::EV_COUNT_ZERO] = zero_event;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = apb_access;
    fault_cnt_next = fault_cnt_reg + {31'h0, fault_event};
    last_cnt_next = last_cnt_reg;
    if (state_reg == ST_WRITE && i_mem_ack) begin
      last_cnt_next = {16'h0000, 16'(wdata_reg[pasid_entry_pkg::PSE_COUNT_MSB:
                                                pasid_entry_pkg::PSE_COUNT_LSB])};
    end
    hit = 1'b1;
    if (apb_access) begin
      case (i_paddr)
        pasid_entry_pkg::REG_CTRL: begin
          prdata_next = ctrl_reg;
          if (i_pwrite) begin
            ctrl_next = {30'h0, i_pwdata[1:0]};
          end
        end
        pasid_entry_pkg::REG_STATUS: begin
          prdata_next = {29'h0, status_reg};
          if (!i_pwrite) begin
            status_next = '0;
          end
        end
        pasid_entry_pkg::REG_MASK: begin
          prdata_next = {29'h0, mask_reg};
          if (i_pwrite) begin
            mask_next = i_pwdata[2:0];
          end
        end
        pasid_entry_pkg::REG_LAST_COUNT: prdata_next = last_cnt_reg;
        pasid_entry_pkg::REG_FAULT_COUNT: prdata_next = fault_cnt_reg;
        default: begin
          hit = 1'b0;
          prdata_next = 32'h0000_0000;
        end
      endcase
      pslverr_next = !hit;
    end
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ctrl_reg <= pasid_entry_pkg::CTRL_RESET;
      status_reg <= '0;
      mask_reg <= '0;
      fault_cnt_reg <= '0;
      last_cnt_reg <= '0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      look_done_reg <= 1'b0;
      look_ok_reg <= 1'b0;
      root_reg <= '0;
      guest_reg <= 1'b0;
      mtype_reg <= pasid_entry_pkg::MT_WRITE_BACK;
      frep_reg <= 1'b0;
      freason_reg <= pasid_entry_pkg::FLT_NONE;
      state_reg <= ST_IDLE;
      act_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      sync_reg <= 1'b0;
      inuse_reg <= 1'b0;
      udone_reg <= 1'b0;
      idle_reg <= 1'b1;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      fault_cnt_reg <= fault_cnt_next;
      last_cnt_reg <= last_cnt_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      look_done_reg <= look_done_next;
      look_ok_reg <= look_ok_next;
      root_reg <= root_next;
      guest_reg <= guest_next;
      mtype_reg <= mtype_next;
      frep_reg <= frep_next;
      freason_reg <= freason_next;
      state_reg <= state_next;
      act_reg <= act_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      sync_reg <= sync_next;
      inuse_reg <= inuse_next;
      udone_reg <= udone_next;
      idle_reg <= idle_next;
      busy_reg <= busy_next;
      wr_reg <= wr_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign o_lookup_done = look_done_reg;
  assign o_lookup_ok = look_ok_reg;
  assign o_first_level_root_pointer = root_reg;
  assign o_root_is_guest_physical = guest_reg;
  assign o_table_memory_type = mtype_reg;
  assign o_fault_report = frep_reg;
  assign o_fault_reason = freason_reg;
  assign o_update_ready = idle_reg;
  assign o_update_done = udone_reg;
  assign o_sync_flag = sync_reg;
  assign o_pasid_in_use = inuse_reg;
  assign o_mem_req = busy_reg;
  assign o_mem_write = wr_reg;
  assign o_mem_lock = busy_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_irq = irq_reg;
endmodule

// file: sim/pasid_entry_checker.sv
// concurrent checks on the ports of the pasid entry state handler
`timescale 1ns/10ps
module pasid_entry_checker #(
  parameter int HOST_ADDR_WIDTH = 48,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_lookup_valid,
  input wire logic [63:0] i_ctx_entry,
  input wire logic i_nested_translation_enable,
  input wire logic [63:0] i_pasid_entry,
  input wire logic i_supervisor_req,
  input wire logic o_lookup_ok,
  input wire logic [63:0] o_first_level_root_pointer,
  input wire logic o_root_is_guest_physical,
  input wire logic o_fault_report,
  input wire logic [2:0] o_fault_reason,
  input wire logic i_update_valid,
  input wire logic o_update_ready,
  input wire logic o_update_done,
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic o_mem_lock
);
  // ----------------------------------------------------------------
  // lookup decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  absent_context_a: assert property (i_lookup_valid && !i_ctx_entry[0] |=> !o_lookup_ok
    && o_fault_reason == 3'h1 && o_fault_report == !$past(i_ctx_entry[1]))
    else $error("absent context entry handled wrongly");
  fault_suppress_a: assert property (i_lookup_valid && i_ctx_entry[1] |=> !o_fault_report)
    else $error("suppressed fault was reported");
  pasid_invalid_a: assert property (i_lookup_valid && i_ctx_entry[0] && !i_pasid_entry[0]
    |=> !o_lookup_ok && o_fault_reason == 3'h2) else $error("invalid pasid entry accepted");
  root_high_a: assert property (i_lookup_valid && (&i_ctx_entry[0] ) && i_pasid_entry[0]
    && i_pasid_entry[63] |=> !o_lookup_ok) else $error("root pointer high bit accepted");
  root_pointer_a: assert property (o_lookup_ok |->
    o_first_level_root_pointer == {$past(i_pasid_entry[63:12]), 12'h000})
    else $error("root pointer not taken from entry");
  guest_root_a: assert property (o_lookup_ok |->
    o_root_is_guest_physical == $past(i_nested_translation_enable))
    else $error("guest physical marking wrong");
  supervisor_block_a: assert property (i_lookup_valid && i_ctx_entry[0] && i_pasid_entry[0]
    && !i_pasid_entry[11] && i_supervisor_req |=> !o_lookup_ok)
    else $error("supervisor request not blocked");
  // ----------------------------------------------------------------
  // locked state update
  // ----------------------------------------------------------------
  write_locked_a: assert property (o_mem_write |-> o_mem_req && o_mem_lock)
    else $error("write phase without lock");
  read_first_a: assert property ($rose(o_mem_req) |-> o_mem_lock && !o_mem_write)
    else $error("update does not start with locked read");
  update_done_a: assert property (i_update_valid && o_update_ready |-> ##[4:60] o_update_done)
    else $error("state update never completed");
endmodule
bind pasid_entry_state_handler pasid_entry_checker #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH),
  .COUNT_WIDTH(COUNT_WIDTH)) chk (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_lookup_valid(i_lookup_valid), .i_ctx_entry(i_ctx_entry),
  .i_nested_translation_enable(i_nested_translation_enable), .i_pasid_entry(i_pasid_entry),
  .i_supervisor_req(i_supervisor_req), .o_lookup_ok(o_lookup_ok),
  .o_first_level_root_pointer(o_first_level_root_pointer),
  .o_root_is_guest_physical(o_root_is_guest_physical),
  .o_fault_report(o_fault_report), .o_fault_reason(o_fault_reason),
  .i_update_valid(i_update_valid), .o_update_ready(o_update_ready),
  .o_update_done(o_update_done), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
  .o_mem_lock(o_mem_lock));

// file: sim/state_mem_model.sv
// behavioural memory holding pasid state entries for the locked update port
`timescale 1ns/10ps
module state_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [63:0] i_addr,
  input wire logic [63:0] i_wdata,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [63:0] o_rdata
);
  logic [63:0] store [4]; // four entries, index from address bits 4:3
  int wait_cnt = 0; // cycles waited in the current phase
  initial o_ack = 1'b0;
  initial o_rdata = 64'h0;
  // answer each phase once after the programmed delay; read data toggles outside read answers
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_cnt >= int'(i_delay)) begin
        o_ack <= 1'b1;
        wait_cnt <= 0;
        if (i_write) store[i_addr[4:3]] <= i_wdata;
        else o_rdata <= store[i_addr[4:3]];
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

// file: sim/testbench.sv
// self-checking bench for the pasid entry state handler
`timescale 1ns/10ps
module testbench;
  logic I_CLOCK = 1'b0;
  logic I_RST = 1'b1;
  logic lk_valid = 1'b0, nest = 1'b0, sup = 1'b0, coh = 1'b0, memcap = 1'b1;
  logic uvalid = 1'b0, uact = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [63:0] ctx = 64'h0, pe = 64'h0, uaddr = 64'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] dly = 4'h0; // memory answer delay
  wire lk_done, lk_ok, guest, frep, uready, udone, sync, inuse, mreq, mwr, mlock, ack, pready;
  wire perr, irq;
  wire [63:0] root, maddr, mwdata, mrdata;
  wire [1:0] mtype;
  wire [2:0] reason;
  wire [31:0] prdata;
  int mismatches = 0, n_checks = 0, nfault = 0;
  always #25 I_CLOCK = ~I_CLOCK;
  pasid_entry_state_handler dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_lookup_valid(lk_valid),
    .i_ctx_entry(ctx), .i_nested_translation_enable(nest), .i_pasid_entry(pe),
    .i_supervisor_req(sup), .i_coherent_domain(coh), .o_lookup_done(lk_done),
    .o_lookup_ok(lk_ok), .o_first_level_root_pointer(root), .o_root_is_guest_physical(guest),
    .o_table_memory_type(mtype), .o_fault_report(frep), .o_fault_reason(reason),
    .i_update_valid(uvalid), .i_update_activate(uact), .i_update_addr(uaddr),
    .o_update_ready(uready), .o_update_done(udone), .o_sync_flag(sync), .o_pasid_in_use(inuse),
    .o_mem_req(mreq), .o_mem_write(mwr), .o_mem_lock(mlock), .o_mem_addr(maddr),
    .o_mem_wdata(mwdata), .i_mem_ack(ack), .i_mem_rdata(mrdata), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .o_irq(irq));
  state_mem_model mem (.i_clk(I_CLOCK), .i_req(mreq), .i_write(mwr), .i_addr(maddr),
    .i_wdata(mwdata), .i_delay(dly), .o_ack(ack), .o_rdata(mrdata));
  // ----------------------------------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // apb transfer: setup, access, hold until pready seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge I_CLOCK);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLOCK);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge I_CLOCK);
      if (pready === 1'b1) break;
    end
    if (i == 20) mismatches++;
    if (i == 20) print_verdict();
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one lookup with its expected answer
  task automatic lk(input logic [63:0] c, input logic [63:0] p, input logic s, input logic h,
      input logic ok, input logic rep, input logic [2:0] why);
    @(posedge I_CLOCK);
    lk_valid <= 1'b1;
    ctx <= c;
    pe <= p;
    sup <= s;
    coh <= h;
    nest <= p[3];
    @(posedge I_CLOCK);
    lk_valid <= 1'b0;
    #1;
    chk(lk_done, 1, "done");
    chk({lk_ok, frep, reason}, {ok, rep, why}, "lookup result");
    if (ok) chk(root, {p[63:12], 12'h000}, "root");
    if (ok) chk({guest, mtype}, {p[3], (h && memcap) ? p[4:3] : 2'h0}, "root type");
    if (rep) nfault++;
  endtask
  // one state update, then its flags and the stored entry
  task automatic upd(input logic act, input logic s, input logic u, input logic [63:0] m);
    int i;
    chk(uready, 1, "ready");
    @(posedge I_CLOCK);
    uvalid <= 1'b1;
    uact <= act;
    uaddr <= 64'h8;
    @(posedge I_CLOCK);
    uvalid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      #1;
      if (udone === 1'b1) break;
      @(posedge I_CLOCK);
    end
    if (i == 60) mismatches++;
    if (i == 60) print_verdict();
    chk({sync, inuse}, {s, u}, "update flags");
    chk(mem.store[1], m, "entry");
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] p;
    p = 64'h0000_1234_5678_9801;
    repeat (16) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, (a == 0) ? 32'h3 : 32'h0, "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, pasid_entry_pkg::REG_MASK, 32'h1);
    $display("registers done");
    for (int t = 0; t < 4; t++) lk(64'h1, p | 64'(t << 3), 1'b1, 1'b1, 1, 0, 3'h0);
    lk(64'h1, p | 64'h18, 1'b0, 1'b0, 1, 0, 3'h0);
    lk(64'h0, p, 1'b0, 1'b1, 0, 1, 3'h1);
    lk(64'h2, p, 1'b0, 1'b1, 0, 0, 3'h1);
    lk(64'h3, 64'h0, 1'b0, 1'b1, 0, 0, 3'h2);
    lk(64'h1, 64'h0, 1'b0, 1'b1, 0, 1, 3'h2);
    lk(64'h1, p | 64'h8000_0000_0000_0000, 1'b0, 1'b1, 0, 1, 3'h3);
    lk(64'h1, p & ~64'h800, 1'b1, 1'b1, 0, 1, 3'h4);
    apb(1'b1, pasid_entry_pkg::REG_CTRL, 32'h0);
    memcap = 1'b0;
    lk(64'h1, p, 1'b0, 1'b1, 0, 1, 3'h3);
    lk(64'h1, (p & ~64'h800) | 64'h10, 1'b0, 1'b1, 0, 1, 3'h3);
    lk(64'h1, p & ~64'h800, 1'b0, 1'b1, 1, 0, 3'h0);
    apb(1'b1, pasid_entry_pkg::REG_CTRL, 32'h3);
    memcap = 1'b1;
    apb(1'b0, pasid_entry_pkg::REG_FAULT_COUNT, 32'h0);
    chk(rd, 32'(nfault), "fault count");
    chk(irq, 1, "irq raised");
    apb(1'b0, pasid_entry_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1, "status");
    @(posedge I_CLOCK);
    #1;
    chk(irq, 0, "irq cleared");
    $display("lookups done");
    mem.store[1] = 64'h8000_0000_0000_00FF;
    upd(1'b1, 1'b1, 1'b1, 64'h0000_0001_0000_0000);
    chk(irq, 0, "masked event");
    dly <= 4'h3;
    upd(1'b1, 1'b0, 1'b1, 64'h0000_0002_0000_0000);
    upd(1'b0, 1'b0, 1'b1, 64'h0000_0001_0000_0000);
    upd(1'b0, 1'b0, 1'b0, 64'h0);
    apb(1'b0, pasid_entry_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h6, "status events");
    apb(1'b0, pasid_entry_pkg::REG_LAST_COUNT, 32'h0);
    chk(rd, 32'h0, "last count");
    upd(1'b0, 1'b0, 1'b1, 64'h0000_FFFF_0000_0000);
    $display("updates done");
    print_verdict();
  end
endmodule
